// file: common/sign_abs_angle_consts.svh
// Constants for the sign, magnitude and angle conversion unit.
// Assumes inclusion by the design file by bare name.
`ifndef SIGN_ABS_ANGLE_CONSTS_SVH
`define SIGN_ABS_ANGLE_CONSTS_SVH

// Single precision field layout
`define FP_SIGN_BIT     31
`define FP_EXP_HI       30
`define FP_EXP_LO       23
`define FP_MAN_HI       22
`define FP_EXP_BIAS     8'h7F
`define FP_EXP_INF      8'hFF
// 180/pi as a 24-bit mantissa with hidden one, value 57.2957795
`define RAD2DEG_MANT    24'hE52EE1
// Exponent of 180/pi is 2^5
`define RAD2DEG_EXP     8'h05
// Limit 1e37 as a single precision bit pattern
`define RANGE_LIMIT     32'h7CF0BDC2
// Operand word widths
`define WORD_WIDTH      16
`define DWORD_WIDTH     32
// Flag reset values
`define ERR_RESET       1'b0
`define CARRY_RESET     1'b0

`endif

// file: common/sign_abs_angle_pkg.sv
// Types shared by the sign, magnitude and angle conversion unit.
// Assumes no surroundings; the consts header is not used here.
package sign_abs_angle_pkg;

    typedef enum logic [1:0] {
        OP_MAGNITUDE  = 2'h0,
        OP_SIGN_APPLY = 2'h1,
        OP_RAD_ANGLE  = 2'h2,
        OP_NONE       = 2'h3
    } op_e;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'h1,
        ST_EXEC  = 3'h2,
        ST_DONE  = 3'h4
    } state_e;

endpackage

// file: src/sign_abs_angle_unit.sv
// Execution datapath for magnitude, sign apply and radian-to-degree ops.
// Assumes start pulses from the sequencer on mclk and operands valid
// in the start cycle, where they are latched.
`timescale 1ns/1ps
`include "sign_abs_angle_consts.svh"

module sign_abs_angle_unit #(
    parameter int WIDTH_W = `WORD_WIDTH,
    parameter int WIDTH_D = `DWORD_WIDTH
) (
    input  wire logic                          mclk,       // 10 MHz clock
    input  wire logic                          reset,      // Async, high
    input  wire logic                          start,      // One-cycle start
    input  wire sign_abs_angle_pkg::op_e       op,         // Operation
    input  wire logic                          dword_sel,  // 1: double word
    input  wire logic [WIDTH_D-1:0]            src,        // Source operand
    output logic      [WIDTH_D-1:0]            dest,       // Result
    output logic                               done,       // Result pulse
    output logic                               busy,       // Op in progress
    output logic                               carry_flag, // Carry flag
    output logic                               data_error_flag // Data error
);

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    // Two's complement negate at either width; upper half zero for words
    function automatic logic [WIDTH_D-1:0] negate(
        input logic [WIDTH_D-1:0] v,
        input logic               dw
    );
        logic [WIDTH_D-1:0] n;
        n = (~v) + {{(WIDTH_D-1){1'b0}}, 1'b1};
        if (dw) begin
            negate = n;
        end else begin
            negate = {{(WIDTH_D-WIDTH_W){1'b0}}, n[WIDTH_W-1:0]};
        end
    endfunction

    // Narrow to the selected width
    function automatic logic [WIDTH_D-1:0] fit(
        input logic [WIDTH_D-1:0] v,
        input logic               dw
    );
        if (dw) begin
            fit = v;
        end else begin
            fit = {{(WIDTH_D-WIDTH_W){1'b0}}, v[WIDTH_W-1:0]};
        end
    endfunction

    // Sign bit at the selected width
    function automatic logic sign_of(
        input logic [WIDTH_D-1:0] v,
        input logic               dw
    );
        sign_of = dw ? v[WIDTH_D-1] : v[WIDTH_W-1];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Sequencing

    sign_abs_angle_pkg::state_e state_reg;
    sign_abs_angle_pkg::op_e    op_reg;
    logic                       dw_reg;
    logic [WIDTH_D-1:0]         src_reg;

    sign_abs_angle_pkg::state_e state_next;
    logic                       accept;
    logic                       exec_cycle;

    // A start is only honoured from idle with a real operation code;
    // a start held high while busy is dropped, not queued
    assign accept = (state_reg == sign_abs_angle_pkg::ST_IDLE) && start &&
                    (op != sign_abs_angle_pkg::OP_NONE);

    // The single cycle in which result and flags may be written
    assign exec_cycle = (state_reg == sign_abs_angle_pkg::ST_EXEC);

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            sign_abs_angle_pkg::ST_IDLE: begin
                if (accept) begin
                    state_next = sign_abs_angle_pkg::ST_EXEC;
                end
            end
            sign_abs_angle_pkg::ST_EXEC: begin
                state_next = sign_abs_angle_pkg::ST_DONE;
            end
            sign_abs_angle_pkg::ST_DONE: begin
                state_next = sign_abs_angle_pkg::ST_IDLE;
            end
            default: begin
                state_next = sign_abs_angle_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            state_reg <= sign_abs_angle_pkg::ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Op is latched at start so a changing op input cannot split one run

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            op_reg  <= sign_abs_angle_pkg::OP_NONE;
            dw_reg  <= 1'b0;
            src_reg <= '0;
        end else if (state_reg == sign_abs_angle_pkg::ST_IDLE && start) begin
            op_reg  <= op;
            dw_reg  <= dword_sel;
            src_reg <= src;
        end
    end

    assign busy = (state_reg != sign_abs_angle_pkg::ST_IDLE);

    ////////////////////////////////////////////////////////////////////////
    // Angle conversion: float multiply by 180/pi, truncating rounding

    logic        f_sign;
    logic [7:0]  f_exp;
    logic [23:0] f_man;
    logic [47:0] prod;
    logic [9:0]  exp_sum;
    logic [22:0] r_man;
    logic [9:0]  r_exp;
    logic [31:0] fp_result;
    logic        fp_over;
    logic        fp_nan;

    always_comb begin
        f_sign  = src_reg[`FP_SIGN_BIT];
        f_exp   = src_reg[`FP_EXP_HI:`FP_EXP_LO];
        f_man   = {1'b1, src_reg[`FP_MAN_HI:0]};
        prod    = f_man * `RAD2DEG_MANT;
        exp_sum = {2'b00, f_exp} + {2'b00, `RAD2DEG_EXP};
        if (prod[47]) begin
            r_man = prod[46:24];
            r_exp = exp_sum + 10'h001;
        end else begin
            r_man = prod[45:23];
            r_exp = exp_sum;
        end
        fp_nan  = (f_exp == `FP_EXP_INF);
        fp_over = fp_nan || (r_exp >= {2'b00, `FP_EXP_INF});
        if (f_exp == 8'h00) begin
            // Zero and denormal inputs flush to signed zero
            fp_result = {f_sign, 31'h00000000};
        end else if (fp_over) begin
            fp_result = {f_sign, `FP_EXP_INF, 23'h000000};
        end else begin
            fp_result = {f_sign, r_exp[7:0], r_man};
        end
    end

    // Range test on the bit pattern: with the sign stripped, a larger
    // pattern of a finite float is a larger magnitude, so no float compare
    // is needed. Exponent overflow is flagged first, since the saturated
    // pattern says nothing about the true size of the result.
    localparam logic [31:0] LIMIT_BITS = `RANGE_LIMIT;

    function automatic logic beyond_limit(
        input logic [31:0] f,
        input logic        ovf
    );
        logic [30:0] mag;
        mag = f[30:0];
        beyond_limit = ovf || (mag > LIMIT_BITS[30:0]);
    endfunction

    logic fp_range_err;
    assign fp_range_err = beyond_limit(fp_result, fp_over);

    ////////////////////////////////////////////////////////////////////////
    // Result and flags, written once in the exec cycle

    logic [WIDTH_D-1:0] dest_next;
    logic               carry_next;
    logic               err_next;

    always_comb begin
        dest_next  = dest;
        carry_next = carry_flag;
        err_next   = data_error_flag;
        case (op_reg)
            sign_abs_angle_pkg::OP_MAGNITUDE: begin
                if (sign_of(src_reg, dw_reg)) begin
                    dest_next  = negate(src_reg, dw_reg);
                    carry_next = 1'b1;
                end else begin
                    dest_next  = fit(src_reg, dw_reg);
                    carry_next = 1'b0;
                end
            end
            sign_abs_angle_pkg::OP_SIGN_APPLY: begin
                if (carry_flag) begin
                    dest_next = negate(src_reg, dw_reg);
                end else begin
                    dest_next = fit(src_reg, dw_reg);
                end
            end
            sign_abs_angle_pkg::OP_RAD_ANGLE: begin
                dest_next = fp_result;
                err_next  = fp_range_err;
            end
            default: begin
                dest_next = dest;
            end
        endcase
    end

    // Destination register: written only in the exec cycle, so a start
    // that is refused leaves the last result standing
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            dest <= '0;
        end else if (exec_cycle) begin
            dest <= dest_next;
        end
    end

    // Condition flags: each op passes through the flag it does not own,
    // so one write per run covers every op
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            carry_flag      <= `CARRY_RESET;
            data_error_flag <= `ERR_RESET;
        end else if (exec_cycle) begin
            carry_flag      <= carry_next;
            data_error_flag <= err_next;
        end
    end

    // Done is registered from the exec cycle, so it rises together with
    // the new result and flags and stands for one cycle only
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            done <= 1'b0;
        end else begin
            done <= exec_cycle;
        end
    end

endmodule

// file: test/sign_abs_angle_unit_props.sv
// Port checker for the sign, magnitude and angle unit.
// Assumes the unit's two-edge answer and is attached by bind below.
`timescale 1ns/1ps
module sign_abs_angle_unit_props #(
    parameter int WIDTH_W = 16,
    parameter int WIDTH_D = 32
) (
    input wire logic                     mclk,            // Clock
    input wire logic                     reset,           // Async reset
    input wire logic                     start,           // Start pulse
    input wire sign_abs_angle_pkg::op_e  op,              // Operation
    input wire logic                     dword_sel,       // Width select
    input wire logic [WIDTH_D-1:0]       src,             // Source
    input wire logic [WIDTH_D-1:0]       dest,            // Result
    input wire logic                     done,            // Result pulse
    input wire logic                     busy,            // In progress
    input wire logic                     carry_flag,      // Carry
    input wire logic                     data_error_flag  // Data error
);
////////////////////////////////////////
    logic               take;
    logic               sgn;
    logic [WIDTH_D-1:0] wd;
    logic [WIDTH_D-1:0] neg;
    logic [7:0]         ex;
    assign take = start && !busy && op != sign_abs_angle_pkg::OP_NONE;
    assign sgn = dword_sel ? src[WIDTH_D-1] : src[WIDTH_W-1];
    assign wd = dword_sel ? src : {16'h0000, src[15:0]};
    assign neg = dword_sel ? -src : {16'h0000, -src[15:0]};
    assign ex = src[30:23];
////////////////////////////////////////
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    sequence s_answer;
        busy ##1 (busy && done) ##1 !done;
    endsequence
    property p_latency; take |=> s_answer; endproperty
    property p_refuse;
        start && !busy && op == sign_abs_angle_pkg::OP_NONE |=> !busy;
    endproperty
    property p_hold;
        !done |-> $stable(dest) && $stable(carry_flag)
            && $stable(data_error_flag);
    endproperty
    property p_mag;
        take && op == sign_abs_angle_pkg::OP_MAGNITUDE |-> ##2
            dest == $past(sgn ? neg : wd, 2) && carry_flag == $past(sgn, 2);
    endproperty
    property p_sa_val;
        take && op == sign_abs_angle_pkg::OP_SIGN_APPLY |-> ##2
            dest == $past(carry_flag ? neg : wd, 2);
    endproperty
    property p_sa_carry;
        take && op != sign_abs_angle_pkg::OP_MAGNITUDE |-> ##2
            carry_flag == $past(carry_flag, 2);
    endproperty
    property p_int_err;
        take && op != sign_abs_angle_pkg::OP_RAD_ANGLE |-> ##2
            data_error_flag == $past(data_error_flag, 2);
    endproperty
    property p_ang_inf;
        take && op == sign_abs_angle_pkg::OP_RAD_ANGLE && ex == 8'hFF
            |-> ##2 data_error_flag;
    endproperty
    property p_ang_zero;
        take && op == sign_abs_angle_pkg::OP_RAD_ANGLE && ex == 8'h00
            |-> ##2 !data_error_flag && dest[30:0] == 31'h00000000;
    endproperty
    a_latency: assert property (p_latency)
        else $error("done not two edges after a start");
    a_refuse: assert property (p_refuse)
        else $error("idle operation code started work");
    a_hold: assert property (p_hold)
        else $error("result or flags moved without done");
    a_mag: assert property (p_mag)
        else $error("magnitude result or carry wrong");
    a_sa_val: assert property (p_sa_val)
        else $error("sign apply result wrong");
    a_sa_carry: assert property (p_sa_carry)
        else $error("carry changed by a non-magnitude op");
    a_int_err: assert property (p_int_err)
        else $error("integer op changed the data error flag");
    a_ang_inf: assert property (p_ang_inf)
        else $error("infinite angle input left error clear");
    a_ang_zero: assert property (p_ang_zero)
        else $error("zero angle input gave a wrong result");
endmodule
bind sign_abs_angle_unit sign_abs_angle_unit_props #(
    .WIDTH_W(WIDTH_W), .WIDTH_D(WIDTH_D)) props_i (
    .mclk(mclk), .reset(reset), .start(start), .op(op),
    .dword_sel(dword_sel), .src(src), .dest(dest), .done(done),
    .busy(busy), .carry_flag(carry_flag),
    .data_error_flag(data_error_flag));

// file: test/sign_abs_angle_unit_tb_top.sv
// Self-checking bench for the sign, magnitude and angle unit.
// Assumes the checker is bound to the unit from its own file.
`timescale 1ns/1ps
module sign_abs_angle_unit_tb_top;
    localparam sign_abs_angle_pkg::op_e MAG = sign_abs_angle_pkg::OP_MAGNITUDE;
    localparam sign_abs_angle_pkg::op_e SGA = sign_abs_angle_pkg::OP_SIGN_APPLY;
    localparam sign_abs_angle_pkg::op_e ANG = sign_abs_angle_pkg::OP_RAD_ANGLE;
    logic                    mclk = 1'b0;
    logic                    reset = 1'b1;
    logic                    start = 1'b0;
    sign_abs_angle_pkg::op_e op = sign_abs_angle_pkg::OP_NONE;
    logic                    dword_sel = 1'b0;
    logic [31:0]             src = 32'h00000000;
    logic [31:0]             dest;
    logic                    done;
    logic                    busy;
    logic                    carry_flag;
    logic                    data_error_flag;
    int                      bad_count = 0;
    int                      check_count = 0;
    int                      cycles = 0;
    sign_abs_angle_unit sign_abs_angle_unit_i (
        .mclk(mclk), .reset(reset), .start(start), .op(op),
        .dword_sel(dword_sel), .src(src), .dest(dest), .done(done),
        .busy(busy), .carry_flag(carry_flag),
        .data_error_flag(data_error_flag));
    initial forever #50 mclk = ~mclk;
    // Cut a hang well beyond the some 62 cycles the run needs
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 2000) begin
            bad_count++;
            print_verdict();
        end
    end
////////////////////////////////////////
    task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    // Spacing of three cycles: busy still stands in the done cycle
    task automatic issue(sign_abs_angle_pkg::op_e o, logic dw, logic [31:0] s);
        @(negedge mclk);
        op = o;
        dword_sel = dw;
        src = s;
        start = 1'b1;
        @(negedge mclk);
        start = 1'b0;
        @(negedge mclk);
        chk("done", 32'h1, {31'h0, done});
    endtask
    task automatic run(sign_abs_angle_pkg::op_e o, logic dw, logic [31:0] s,
                       logic [31:0] ed, logic ec, logic ee);
        issue(o, dw, s);
        chk("dest", ed, dest);
        chk("carry", {31'h0, ec}, {31'h0, carry_flag});
        chk("error", {31'h0, ee}, {31'h0, data_error_flag});
    endtask
////////////////////////////////////////
    task automatic t_magnitude;
        run(MAG, 1'b0, 32'h00003039, 32'h00003039, 1'b0, 1'b0);
        run(MAG, 1'b0, 32'h0000CFC7, 32'h00003039, 1'b1, 1'b0);
        run(MAG, 1'b0, 32'hFFFF8000, 32'h00008000, 1'b1, 1'b0);
        run(MAG, 1'b1, 32'hFFFFFFFF, 32'h00000001, 1'b1, 1'b0);
        run(MAG, 1'b1, 32'h7FFFFFFF, 32'h7FFFFFFF, 1'b0, 1'b0);
    endtask
    task automatic t_sign_apply;
        run(MAG, 1'b0, 32'h00008001, 32'h00007FFF, 1'b1, 1'b0);
        run(SGA, 1'b0, 32'h00003039, 32'h0000CFC7, 1'b1, 1'b0);
        run(SGA, 1'b1, 32'h00000001, 32'hFFFFFFFF, 1'b1, 1'b0);
        run(MAG, 1'b1, 32'h00000005, 32'h00000005, 1'b0, 1'b0);
        run(SGA, 1'b1, 32'h80000001, 32'h80000001, 1'b0, 1'b0);
        run(SGA, 1'b0, 32'hABCD8001, 32'h00008001, 1'b0, 1'b0);
    endtask
    task automatic t_angle;
        issue(ANG, 1'b1, 32'h7A800000);
        chk("error", 32'h1, {31'h0, data_error_flag});
        run(ANG, 1'b1, 32'h00000000, 32'h00000000, 1'b0, 1'b0);
        issue(ANG, 1'b1, 32'hFA800000);
        chk("error", 32'h1, {31'h0, data_error_flag});
        issue(ANG, 1'b1, 32'h7A000000);
        chk("error", 32'h0, {31'h0, data_error_flag});
        issue(ANG, 1'b1, 32'h7F800000);
        chk("error", 32'h1, {31'h0, data_error_flag});
        // Pi in gives about 180.0; truncation may cost a few units
        issue(ANG, 1'b1, 32'h40490FDB);
        chk("error", 32'h0, {31'h0, data_error_flag});
        chk("angle", 32'h1, {31'h0, dest >= 32'h4333FFF0
            && dest <= 32'h43340010});
    endtask
    task automatic t_refuse;
        @(negedge mclk);
        op = MAG;
        dword_sel = 1'b0;
        src = 32'h00000011;
        start = 1'b1;
        @(negedge mclk);
        src = 32'h0000FFFF;
        @(negedge mclk);
        start = 1'b0;
        chk("dest", 32'h00000011, dest);
        @(negedge mclk);
        chk("done", 32'h0, {31'h0, done});
        op = sign_abs_angle_pkg::OP_NONE;
        start = 1'b1;
        @(negedge mclk);
        start = 1'b0;
        chk("busy", 32'h0, {31'h0, busy});
        repeat (3) @(negedge mclk);
        chk("dest", 32'h00000011, dest);
    endtask
////////////////////////////////////////
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (3) @(negedge mclk);
        reset = 1'b0;
        chk("dest", 32'h00000000, dest);
        t_magnitude();
        t_sign_apply();
        t_angle();
        t_refuse();
        print_verdict();
    end
endmodule
